/* dlc_pkg.sv */
package dlc_pkg;
    // register offsets of the deframer map (index form, byte addr = 4*index)
    localparam logic [11:0] DLC_OFF_SOFT_RESET  = 12'h475;
    localparam logic [11:0] DLC_OFF_CTRL_ONE    = 12'h476;
    localparam logic [11:0] DLC_OFF_CTRL_TWO    = 12'h477;
    localparam logic [11:0] DLC_OFF_ALIGN_MF    = 12'h478;
    localparam logic [11:0] DLC_OFF_ERR_THRESH  = 12'h47C;
    localparam logic [11:0] DLC_OFF_RESYNC_MASK = 12'h47D;
    localparam logic [11:0] DLC_OFF_LANE0_ECNT  = 12'h480;
    // controller's own AXI registers
    localparam logic [7:0]  DLC_AXI_CMD         = 8'h00;
    localparam logic [7:0]  DLC_AXI_WDATA       = 8'h04;
    localparam logic [7:0]  DLC_AXI_RDATA       = 8'h08;
    localparam logic [7:0]  DLC_AXI_IRQ_STATUS  = 8'h0C;
    localparam logic [7:0]  DLC_AXI_IRQ_MASK    = 8'h10;
    localparam logic [7:0]  DLC_AXI_DEV_STATUS  = 8'h14;
    // field positions
    localparam int DLC_SOFT_RESET_BIT  = 3;
    localparam int DLC_SKIP_ALIGN_BIT  = 1;
    localparam int DLC_CHKSUM_BIT      = 0;
    localparam int DLC_PERP_ALIGN_BIT  = 7;
    localparam int DLC_REPEAT_PAT_BIT  = 5;
    localparam int DLC_QUEUED_ERR_BIT  = 4;
    localparam int DLC_AUTO_CLEAR_BIT  = 3;
    localparam int DLC_ENA_LSB         = 3;
    // error kinds in counter order: 0 disparity, 1 not-in-table, 2 control char
    localparam int DLC_ERR_KINDS       = 3;
    // resync mask is reversed: bit 2 disparity .. bit 0 control char
    // reset values
    localparam logic [7:0] DLC_RST_SOFT_RESET  = 8'h00;
    localparam logic [7:0] DLC_RST_CTRL_ONE    = 8'h00;
    localparam logic [7:0] DLC_RST_CTRL_TWO    = 8'h00;
    localparam logic [7:0] DLC_RST_ALIGN_MF    = 8'h01;
    localparam logic [7:0] DLC_RST_ERR_THRESH  = 8'hFF;
    localparam logic [7:0] DLC_RST_RESYNC_MASK = 8'h07;
    localparam logic [7:0] DLC_RST_LANE0_ECNT  = 8'h3F;
    // writable bits per register (reserved bits read zero)
    localparam logic [7:0] DLC_WM_CTRL_ONE     = 8'h03;
    localparam logic [7:0] DLC_WM_CTRL_TWO     = 8'hB8;
    localparam logic [7:0] DLC_WM_RESYNC_MASK  = 8'h07;
    localparam logic [7:0] DLC_WM_LANE_ECNT    = 8'h3F;
    localparam logic [7:0] DLC_WM_SOFT_RESET   = 8'h08;
    // alignment phase: groups of four multiframes
    localparam int DLC_MF_PER_GROUP = 4;
    // command register
    localparam int DLC_CMD_WRITE_BIT = 12;
    localparam int DLC_CMD_GO_BIT    = 13;
    // irq status bits
    localparam int DLC_IRQ_DONE      = 0;
    localparam int DLC_IRQ_THRESH    = 1;
    localparam int DLC_IRQ_SYNC      = 2;
    localparam int DLC_IRQ_W         = 3;
    // axi answers
    localparam logic [1:0] DLC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] DLC_RESP_SLVERR = 2'b10;
endpackage

/* dlc_link_if.sv */
`timescale 1ns/1ps
interface dlc_link_if #(
    parameter int LANES = 4
);
    // register port
    logic             reg_req;
    logic             reg_write;
    logic [11:0]      reg_addr;
    logic [7:0]       reg_wdata;
    logic [7:0]       reg_rdata;
    logic             reg_ack;
    // link side
    logic [LANES-1:0] lane_bad_disparity_error;
    logic [LANES-1:0] lane_not_in_table_error;
    logic [LANES-1:0] lane_unexpected_control_char_error;
    logic             code_group_sync_done;
    logic             link_sync_request_out;
    logic             link_irq;

    modport device (
        input  reg_req, reg_write, reg_addr, reg_wdata,
        output reg_rdata, reg_ack,
        input  lane_bad_disparity_error, lane_not_in_table_error,
        input  lane_unexpected_control_char_error, code_group_sync_done,
        output link_sync_request_out, link_irq
    );
    modport host (
        output reg_req, reg_write, reg_addr, reg_wdata,
        input  reg_rdata, reg_ack,
        input  link_sync_request_out, link_irq
    );
endinterface

/* dlc_link_deframer.sv */
`timescale 1ns/1ps
// Function
// - skip alignment: data right after sync
// - software keeps skip clear for multilane
// - checksum method: fields or packed bytes
// - perpetual alignment test repeats alignment sequence
// - repeat pattern test needs perpetual off
// - queued mode off: merge lanes; on: report sequentially
// - auto clear resets the triggering counter
// - multiframe groups field, resets to 1
// - count errors, compare to shared threshold
// - threshold applied to every lane
// - threshold hit and mask bit: sync request
// - mask bit order reversed, resets 7
// - lane counter enables bits 5:3, reset 7
// - configure only while in soft reset; the register port accepts writes at any time
// - soft reset restores counters, stops reception
module dlc_link_deframer
    import dlc_pkg::*;
#(
    parameter int LANES = 4
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // register port and link
    dlc_link_if.device        lnk,
    // decoded configuration for the lane datapath
    output      logic         skip_alignment_seq,
    output      logic         checksum_method_sel,
    output      logic         perpetual_alignment_test,
    output      logic         repeat_pattern_test_en,
    output      logic [7:0]   align_multiframe_groups,
    output      logic         deframer_rx_enable
);
    typedef logic [7:0] dlc_byte_t;

    dlc_byte_t soft_reset_q, link_ctrl_one_q, link_ctrl_two_q, align_multiframe_count_q;
    dlc_byte_t error_threshold_q, resync_error_mask_q;
    dlc_byte_t lane_ecnt_ctrl_q [LANES];
    dlc_byte_t err_cnt_q [LANES][DLC_ERR_KINDS];
    dlc_byte_t reg_rdata_q;
    logic      reg_ack_q;
    logic [LANES*DLC_ERR_KINDS-1:0] pending_q;
    logic      sync_out_q;
    logic      irq_q;

    logic in_soft_reset;
    assign in_soft_reset = soft_reset_q[DLC_SOFT_RESET_BIT];

    // register writes; index 0x480+lane selects lane controls
    logic wr;
    assign wr = lnk.reg_req & lnk.reg_write & ~reg_ack_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_q             <= DLC_RST_SOFT_RESET;
            link_ctrl_one_q          <= DLC_RST_CTRL_ONE;
            link_ctrl_two_q          <= DLC_RST_CTRL_TWO;
            align_multiframe_count_q <= DLC_RST_ALIGN_MF;
            error_threshold_q        <= DLC_RST_ERR_THRESH;
            resync_error_mask_q      <= DLC_RST_RESYNC_MASK;
            for (int l = 0; l < LANES; l++) begin
                lane_ecnt_ctrl_q[l] <= DLC_RST_LANE0_ECNT;
            end
        end else if (wr) begin
            case (lnk.reg_addr)
                DLC_OFF_SOFT_RESET:  soft_reset_q        <= lnk.reg_wdata & DLC_WM_SOFT_RESET;
                DLC_OFF_CTRL_ONE:    link_ctrl_one_q     <= lnk.reg_wdata & DLC_WM_CTRL_ONE;
                DLC_OFF_CTRL_TWO:    link_ctrl_two_q     <= lnk.reg_wdata & DLC_WM_CTRL_TWO;
                DLC_OFF_ALIGN_MF:    align_multiframe_count_q <= lnk.reg_wdata;
                DLC_OFF_ERR_THRESH:  error_threshold_q   <= lnk.reg_wdata;
                DLC_OFF_RESYNC_MASK: resync_error_mask_q <= lnk.reg_wdata & DLC_WM_RESYNC_MASK;
                default: begin
                    for (int l = 0; l < LANES; l++) begin
                        if (lnk.reg_addr == DLC_OFF_LANE0_ECNT + 12'(l)) begin
                            lane_ecnt_ctrl_q[l] <= lnk.reg_wdata & DLC_WM_LANE_ECNT;
                        end
                    end
                end
            endcase
        end
    end

    // register reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_ack_q   <= 1'b0;
            reg_rdata_q <= 8'h00;
        end else begin
            reg_ack_q <= lnk.reg_req & ~reg_ack_q;
            if (lnk.reg_req & ~reg_ack_q) begin
                case (lnk.reg_addr)
                    DLC_OFF_SOFT_RESET:  reg_rdata_q <= soft_reset_q;
                    DLC_OFF_CTRL_ONE:    reg_rdata_q <= link_ctrl_one_q;
                    DLC_OFF_CTRL_TWO:    reg_rdata_q <= link_ctrl_two_q;
                    DLC_OFF_ALIGN_MF:    reg_rdata_q <= align_multiframe_count_q;
                    DLC_OFF_ERR_THRESH:  reg_rdata_q <= error_threshold_q;
                    DLC_OFF_RESYNC_MASK: reg_rdata_q <= resync_error_mask_q;
                    default: begin
                        reg_rdata_q <= 8'h00;
                        for (int l = 0; l < LANES; l++) begin
                            if (lnk.reg_addr == DLC_OFF_LANE0_ECNT + 12'(l)) begin
                                reg_rdata_q <= lane_ecnt_ctrl_q[l];
                            end
                        end
                    end
                endcase
            end
        end
    end
    assign lnk.reg_ack   = reg_ack_q;
    assign lnk.reg_rdata = reg_rdata_q;

    // configuration decode
    assign skip_alignment_seq       = link_ctrl_one_q[DLC_SKIP_ALIGN_BIT];
    assign checksum_method_sel      = link_ctrl_one_q[DLC_CHKSUM_BIT];
    assign perpetual_alignment_test = link_ctrl_two_q[DLC_PERP_ALIGN_BIT];
    // perpetual alignment takes priority over the pattern test
    assign repeat_pattern_test_en   = link_ctrl_two_q[DLC_REPEAT_PAT_BIT] & ~perpetual_alignment_test;
    assign align_multiframe_groups  = align_multiframe_count_q;
    assign deframer_rx_enable       = ~in_soft_reset;

    logic queued, auto_clear;
    assign queued     = link_ctrl_two_q[DLC_QUEUED_ERR_BIT];
    assign auto_clear = link_ctrl_two_q[DLC_AUTO_CLEAR_BIT];

    // error inputs by kind, counter order
    logic [DLC_ERR_KINDS-1:0] err_in [LANES];
    logic [LANES*DLC_ERR_KINDS-1:0] hit;
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            err_in[l] = {lnk.lane_unexpected_control_char_error[l],
                         lnk.lane_not_in_table_error[l],
                         lnk.lane_bad_disparity_error[l]};
            for (int k = 0; k < DLC_ERR_KINDS; k++) begin
                // mask bit for kind k is at 2-k
                hit[l*DLC_ERR_KINDS+k] = (err_cnt_q[l][k] == error_threshold_q)
                                         & resync_error_mask_q[DLC_ERR_KINDS-1-k];
            end
        end
    end

    // lowest-index pending hit is served first, one per cycle
    logic [LANES*DLC_ERR_KINDS-1:0] serve;
    assign serve = pending_q & (~pending_q + 1'b1);

    always_ff @(posedge aclk) begin
        if (!aresetn || in_soft_reset) begin
            for (int l = 0; l < LANES; l++) begin
                for (int k = 0; k < DLC_ERR_KINDS; k++) begin
                    err_cnt_q[l][k] <= 8'h00;
                end
            end
        end else begin
            for (int l = 0; l < LANES; l++) begin
                for (int k = 0; k < DLC_ERR_KINDS; k++) begin
                    if (auto_clear && serve[l*DLC_ERR_KINDS+k]) begin
                        err_cnt_q[l][k] <= 8'h00;
                    end else if (err_in[l][k] && lane_ecnt_ctrl_q[l][DLC_ENA_LSB+k]
                                 && err_cnt_q[l][k] != error_threshold_q) begin
                        err_cnt_q[l][k] <= err_cnt_q[l][k] + 8'h01;
                    end
                end
            end
        end
    end

    // pending hits: newly reached thresholds, serve wins over set
    always_ff @(posedge aclk) begin
        if (!aresetn || in_soft_reset) begin
            pending_q <= '0;
        end else begin
            pending_q <= (pending_q & ~serve) | (hit & ~pending_q & ~serve);
        end
    end

    // sync request: queued=0 merges simultaneous lanes into one pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || in_soft_reset) begin
            sync_out_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            sync_out_q <= queued ? (|serve) : (|hit);
            irq_q      <= |hit;
        end
    end
    assign lnk.link_sync_request_out = sync_out_q;
    assign lnk.link_irq              = irq_q;
endmodule

/* dlc_link_host.sv */
`timescale 1ns/1ps
module dlc_link_host
    import dlc_pkg::*;
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite slave
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output      logic         s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output      logic         s_axi_wready,
    output      logic [1:0]   s_axi_bresp,
    output      logic         s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output      logic         s_axi_arready,
    output      logic [31:0]  s_axi_rdata,
    output      logic [1:0]   s_axi_rresp,
    output      logic         s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // interrupt
    output      logic         irq,
    // device side
    dlc_link_if.host          lnk
);
    typedef enum logic [2:0] {
        DLC_IDLE = 3'b001,
        DLC_REQ  = 3'b010,
        DLC_DONE = 3'b100
    } dlc_state_t;

    dlc_state_t state_q;
    logic [13:0] cmd_q;
    logic [7:0]  wdata_q, rdata_q;
    logic [DLC_IRQ_W-1:0] status_q, mask_q;
    logic        aw_q, w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wd_q;
    logic        sync_s1_q, sync_s2_q, sync_prev_q, irq_s1_q, irq_s2_q, irq_prev_q;

    // axi write: hold address and data until both present
    logic wr_fire, rd_fire, start, status_read;
    assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
    assign wr_fire       = aw_q & w_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;
    assign status_read   = rd_fire & (s_axi_araddr == DLC_AXI_IRQ_STATUS);
    assign start         = wr_fire & (awaddr_q == DLC_AXI_CMD) & wd_q[DLC_CMD_GO_BIT] & (state_q == DLC_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wd_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DLC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == DLC_AXI_CMD || awaddr_q == DLC_AXI_WDATA ||
                                awaddr_q == DLC_AXI_IRQ_MASK) ? DLC_RESP_OKAY : DLC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_q <= 8'h00;
            mask_q  <= '0;
            cmd_q   <= '0;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            if (awaddr_q == DLC_AXI_WDATA) wdata_q <= wd_q[7:0];
            if (awaddr_q == DLC_AXI_IRQ_MASK) mask_q <= wd_q[DLC_IRQ_W-1:0];
            if (start) cmd_q <= {wd_q[DLC_CMD_GO_BIT], wd_q[DLC_CMD_WRITE_BIT], wd_q[11:0]};
        end
    end

    // device access sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= DLC_IDLE;
            rdata_q <= 8'h00;
        end else begin
            case (state_q)
                DLC_IDLE: if (start) state_q <= DLC_REQ;
                DLC_REQ: if (lnk.reg_ack) begin
                    state_q <= DLC_DONE;
                    rdata_q <= lnk.reg_rdata;
                end
                DLC_DONE: state_q <= DLC_IDLE;
                default: state_q <= DLC_IDLE;
            endcase
        end
    end
    assign lnk.reg_req   = (state_q == DLC_REQ);
    assign lnk.reg_write = cmd_q[DLC_CMD_WRITE_BIT];
    assign lnk.reg_addr  = cmd_q[11:0];
    assign lnk.reg_wdata = wdata_q;

    // device outputs treated as foreign: two-stage sync
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {sync_s1_q, sync_s2_q, sync_prev_q} <= 3'b000;
            {irq_s1_q, irq_s2_q, irq_prev_q} <= 3'b000;
        end else begin
            sync_s1_q <= lnk.link_sync_request_out;
            sync_s2_q <= sync_s1_q;
            sync_prev_q <= sync_s2_q;
            irq_s1_q <= lnk.link_irq;
            irq_s2_q <= irq_s1_q;
            irq_prev_q <= irq_s2_q;
        end
    end

    // sticky status, cleared by read; a new event wins over the clear
    logic [DLC_IRQ_W-1:0] ev;
    assign ev = {sync_s2_q & ~sync_prev_q, irq_s2_q & ~irq_prev_q, state_q == DLC_DONE};
    always_ff @(posedge aclk) begin
        if (!aresetn) status_q <= '0;
        else status_q <= (status_read ? '0 : status_q) | ev;
    end
    assign irq = |(status_q & mask_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= DLC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= DLC_RESP_OKAY;
            case (s_axi_araddr)
                DLC_AXI_CMD:        s_axi_rdata <= {18'h0, cmd_q};
                DLC_AXI_WDATA:      s_axi_rdata <= {24'h0, wdata_q};
                DLC_AXI_RDATA:      s_axi_rdata <= {24'h0, rdata_q};
                DLC_AXI_IRQ_STATUS: s_axi_rdata <= {29'h0, status_q};
                DLC_AXI_IRQ_MASK:   s_axi_rdata <= {29'h0, mask_q};
                DLC_AXI_DEV_STATUS: s_axi_rdata <= {29'h0, state_q != DLC_IDLE, sync_s2_q, irq_s2_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= DLC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* dlc_link_monitor.sv */
`timescale 1ns/1ps
module dlc_link_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register port
    input wire logic        reg_req,
    input wire logic        reg_write,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_ack,
    // link status
    input wire logic        link_sync_request_out,
    input wire logic        link_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // taken only while the previous answer is not showing
    sequence taken_s;
        reg_req && !reg_ack;
    endsequence
    sequence rd_ack_s(logic [11:0] a);
        reg_ack && !reg_write && reg_addr == a;
    endsequence
    sequence soft_set_s;
        reg_ack && reg_write && reg_addr == 12'h475 && reg_wdata[3];
    endsequence

    ack_timing_a: assert property (taken_s |=> reg_ack)
        else $error("register request not answered next cycle");
    ack_pulse_a: assert property (reg_ack |=> !reg_ack)
        else $error("register ack longer than one cycle");
    ack_cause_a: assert property (reg_ack |-> $past(reg_req))
        else $error("register ack without request");
    req_hold_a: assert property (taken_s |=> reg_req && $stable(reg_addr) && $stable(reg_write))
        else $error("register request changed before ack");
    mask_bits_a: assert property (rd_ack_s(12'h47D) |-> reg_rdata[7:3] == 5'h00)
        else $error("resync mask reserved bits not zero");
    ctrl_bits_a: assert property (rd_ack_s(12'h477) |-> (reg_rdata & 8'h47) == 8'h00)
        else $error("control two reserved bits not zero");
    // one cycle grace: a hit already registered may still show once
    soft_clear_a: assert property (soft_set_s |=> ##1 (!link_irq && !link_sync_request_out) [*3])
        else $error("soft reset left error signalling active");
    // merged mode raises both in one cycle; queued mode raises irq first and keeps it up
    sync_cause_a: assert property ($rose(link_sync_request_out) |-> link_irq)
        else $error("sync request without threshold hit");
    reset_quiet_a: assert property ($rose(aresetn) |-> !link_irq && !link_sync_request_out && !reg_ack)
        else $error("outputs active right after reset");
endmodule

/* test_deframer_link_control_errmon.sv */
`timescale 1ns/1ps
module test_deframer_link_control_errmon;
    import dlc_pkg::*;
    typedef struct {logic [11:0] idx; logic [7:0] rst, wr, exp;} dlc_row_t;
    logic        aclk, aresetn, irq, skip, csel, perp, rep_en, rx_en;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_a;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, align, q;
    logic [31:0] s_axi_wdata, s_axi_rdata, s;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [2:0][3:0] errs;
    int          n_errors, checks, sync_cyc, s0;
    dlc_row_t    rows [8] = '{'{12'h475, 8'h00, 8'h08, 8'h08}, '{12'h476, 8'h00, 8'hFF, 8'h03},
        '{12'h477, 8'h00, 8'hFF, 8'hB8}, '{12'h478, 8'h01, 8'h04, 8'h04}, '{12'h47C, 8'hFF, 8'h03, 8'h03},
        '{12'h47D, 8'h07, 8'hFF, 8'h07}, '{12'h480, 8'h3F, 8'hFF, 8'h3F}, '{12'h47E, 8'h00, 8'hFF, 8'h00}};

    dlc_link_if #(.LANES(4)) u_dlc_link_if ();
    assign u_dlc_link_if.lane_bad_disparity_error          = errs[0];
    assign u_dlc_link_if.lane_not_in_table_error           = errs[1];
    assign u_dlc_link_if.lane_unexpected_control_char_error = errs[2];
    assign u_dlc_link_if.code_group_sync_done              = 1'b1;
    dlc_link_host u_dlc_link_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
        .lnk(u_dlc_link_if));
    dlc_link_deframer #(.LANES(4)) u_dlc_link_deframer (.aclk, .aresetn, .lnk(u_dlc_link_if),
        .skip_alignment_seq(skip), .checksum_method_sel(csel), .perpetual_alignment_test(perp),
        .repeat_pattern_test_en(rep_en), .align_multiframe_groups(align), .deframer_rx_enable(rx_en));
    dlc_link_monitor u_dlc_link_monitor (.aclk, .aresetn, .reg_req(u_dlc_link_if.reg_req),
        .reg_write(u_dlc_link_if.reg_write), .reg_addr(u_dlc_link_if.reg_addr), .reg_wdata(u_dlc_link_if.reg_wdata),
        .reg_rdata(u_dlc_link_if.reg_rdata), .reg_ack(u_dlc_link_if.reg_ack),
        .link_sync_request_out(u_dlc_link_if.link_sync_request_out), .link_irq(u_dlc_link_if.link_irq));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) sync_cyc <= sync_cyc + int'(u_dlc_link_if.link_sync_request_out === 1'b1);

    task automatic bad(input string m);
        n_errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) bad($sformatf("byte %h, wanted %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) bad($sformatf("bit %b, wanted %b", got, exp));
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int t;
        logic aw, w;
        t = 0;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w) && t < 100) begin
            @(posedge aclk);
            t++;
            if (s_axi_awready && !aw) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && !w) s_axi_wvalid <= 1'b0;
            aw = aw || s_axi_awready;
            w = w || s_axi_wready;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && ++t < 100);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // one idle edge so the next call never re-raises a strobe in this step
        @(posedge aclk);
        if (t >= 100) bad("write stalled");
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        int t;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1 && ++t < 100);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1 && ++t < 100);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (t >= 100) bad("read stalled");
    endtask
    // device registers are only reachable through the command register
    task automatic dev(input logic [11:0] idx, input logic wr, input logic [7:0] d);
        int t;
        logic [31:0] st;
        t = 0;
        if (wr) axi_wr(DLC_AXI_WDATA, {24'h0, d});
        axi_wr(DLC_AXI_CMD, {18'h0, 1'b1, wr, idx});
        do axi_rd(DLC_AXI_IRQ_STATUS, st); while (st[DLC_IRQ_DONE] !== 1'b1 && ++t < 20);
        if (t >= 20) bad("device access stuck");
        axi_rd(DLC_AXI_RDATA, s);
        q = s[7:0];
    endtask
    task automatic err(input int kind, input logic [3:0] ln, input int n);
        repeat (n) begin
            @(posedge aclk);
            errs[kind] <= ln;
            @(posedge aclk);
            errs <= '0;
            @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, errs, sync_cyc} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            dev(rows[i].idx, 1'b0, 8'h00);
            chk_byte(q, rows[i].rst);
            dev(rows[i].idx, 1'b1, rows[i].wr);
            dev(rows[i].idx, 1'b0, 8'h00);
            chk_byte(q, rows[i].exp);
        end
        chk_byte({skip, csel, perp, rep_en, rx_en, 3'h0}, 8'hE0);
        chk_byte(align, 8'h04);
        axi_rd(8'h18, s);
        chk_byte({6'h0, resp}, {6'h0, DLC_RESP_SLVERR});
        axi_wr(8'h18, 32'h0);
        chk_byte({6'h0, resp}, {6'h0, DLC_RESP_SLVERR});
        dev(12'h476, 1'b1, 8'h00);
        dev(12'h477, 1'b1, 8'h20);
        dev(12'h475, 1'b1, 8'h00);
        chk_byte({skip, perp, rep_en, rx_en, 4'h0}, 8'h30);
        s0 = sync_cyc;
        err(1, 4'b0001, 2);
        err(1, 4'b0010, 2);
        chk_bit(u_dlc_link_if.link_irq, 1'b0);
        err(1, 4'b0001, 1);
        chk_bit(u_dlc_link_if.link_irq, 1'b1);
        chk_bit(sync_cyc > s0, 1'b1);
        axi_wr(DLC_AXI_IRQ_MASK, 32'h0);
        irq_a = irq;
        axi_wr(DLC_AXI_IRQ_MASK, 32'h7);
        chk_byte({6'h0, resp}, {6'h0, DLC_RESP_OKAY});
        chk_byte({6'h0, irq_a, irq}, 8'h01);
        axi_rd(DLC_AXI_IRQ_STATUS, s);
        chk_byte(s[7:0] & 8'h06, 8'h06);
        chk_bit(irq, 1'b0);
        axi_rd(DLC_AXI_IRQ_STATUS, s);
        chk_byte(s[7:0] & 8'h06, 8'h00);
        // reconfigure under soft reset: auto clear, disparity only on lane 0 off
        dev(12'h475, 1'b1, 8'h08);
        chk_bit(u_dlc_link_if.link_irq, 1'b0);
        dev(12'h477, 1'b1, 8'h08);
        dev(12'h480, 1'b1, 8'h37);
        dev(12'h47D, 1'b1, 8'h04);
        dev(12'h475, 1'b1, 8'h00);
        s0 = sync_cyc;
        err(0, 4'b0001, 3);
        err(2, 4'b0100, 3);
        chk_bit(sync_cyc == s0, 1'b1);
        err(0, 4'b0010, 3);
        chk_bit(sync_cyc > s0, 1'b1);
        chk_bit(u_dlc_link_if.link_irq, 1'b0);
        // queued mode: two lanes hit together, each served once and cleared
        dev(12'h475, 1'b1, 8'h08);
        dev(12'h477, 1'b1, 8'h18);
        dev(12'h475, 1'b1, 8'h00);
        s0 = sync_cyc;
        err(0, 4'b0110, 3);
        chk_bit(sync_cyc - s0 == 2, 1'b1);
        chk_bit(u_dlc_link_if.link_irq, 1'b0);
        // reset in mid-run restores the register defaults
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        dev(12'h47C, 1'b0, 8'h00);
        chk_byte(q, 8'hFF);
        results();
    end
    initial begin
        #2000000;
        bad("watchdog expired");
        results();
    end
endmodule
